/* include/tcpm_defines.vh */
// Constants for the pulse measurement timer channel
`ifndef TCPM_DEFINES_VH
`define TCPM_DEFINES_VH

// APB byte offsets
`define TCPM_A_POWER     8'h00
`define TCPM_A_PRESCALE  8'h04
`define TCPM_A_MODE      8'h08
`define TCPM_A_OUTCTL    8'h0C
`define TCPM_A_TRIGGER   8'h10
`define TCPM_A_ENSTAT    8'h14
`define TCPM_A_COUNT     8'h18
`define TCPM_A_CAPTURE   8'h1C
`define TCPM_A_STATUS    8'h20
`define TCPM_A_NFEN      8'h24

// Mode register fields
`define TCPM_M_IRQOPT    0
`define TCPM_M_MD_HI     3
`define TCPM_M_MD_LO     1
`define TCPM_M_CIS_LO    6
`define TCPM_M_CIS_HI    7
`define TCPM_M_STS_HI    10
`define TCPM_M_STS_LO    8
`define TCPM_M_CKS_HI    15
`define TCPM_M_CKS_LO    14
`define TCPM_M_WMASK     16'hC7CF

// Field encodings
`define TCPM_MD_CAPTURE  3'h2
`define TCPM_MD_ONECOUNT 3'h6
`define TCPM_STS_EDGE    3'h1
`define TCPM_STS_START   3'h2
`define TCPM_CIS_FALL    2'h0
`define TCPM_CIS_RISE    2'h1
`define TCPM_CIS_LOW     2'h2
`define TCPM_CIS_HIGH    2'h3

// Trigger register bits, other single bits
`define TCPM_T_START     0
`define TCPM_T_STOP      1
`define TCPM_OVF_BIT     0

// Reset and count values, prescaler field width
`define TCPM_ZERO16      16'h0000
`define TCPM_ONE16       16'h0001
`define TCPM_FULL16      16'hFFFF
`define TCPM_ZERO32      32'h0000_0000
`define TCPM_PSC_W       4

`endif

/* rtl/tcpm_in_filter.v */
// Input pin synchroniser, noise filter and edge detector
`timescale 1ns/100ps
module tcpm_in_filter
(
    input  wire clk,
    input  wire rst,
    input  wire pin,
    input  wire tick,
    input  wire filt_en,
    output reg  rise,
    output reg  fall
);
    reg meta_q;
    reg sync_q;
    reg samp_q;
    reg lvl_q;

    // Two-stage synchroniser, first stage read only by second
    always @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= pin;
            sync_q <= meta_q;
        end
    end

    // Sample on operating clock ticks; filter needs two equal samples
    always @(posedge clk)
    begin
        if (rst)
        begin
            samp_q <= 1'b0;
            lvl_q  <= 1'b0;
            rise   <= 1'b0;
            fall   <= 1'b0;
        end
        else
        begin
            if (tick)
            begin
                // Edge pulses last a full tick so a divided clock sees them
                rise   <= 1'b0;
                fall   <= 1'b0;
                samp_q <= sync_q;
                if ((!filt_en || samp_q == sync_q) && lvl_q != sync_q)
                begin
                    lvl_q <= sync_q;
                    rise  <= sync_q;
                    fall  <= ~sync_q;
                end
            end
        end
    end
endmodule

/* rtl/tcpm_channel.v */
// Timer channel for pulse interval and level width measurement
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/100ps
`include "tcpm_defines.vh"
module tcpm_channel
(
    input  wire        clk,
    input  wire        srst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        timer_input_pin,
    output reg         chan_interrupt
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_RUN  = 4'b0010;
    localparam [3:0] ST_WAIT = 4'b0100;
    localparam [3:0] ST_MEAS = 4'b1000;

    reg        unit_power_enable_q;
    reg [15:0] unit_prescaler_reg_q;
    reg [15:0] chan_mode_reg_q;
    reg [3:0]  out_ctl_q;
    reg        noise_filter_enable_q;
    reg [15:0] chan_count_reg_q;
    reg [15:0] chan_capture_data_reg_q;
    reg        overflow_flag_q;
    reg        wrap_q;
    reg        first_q;
    reg [3:0]  state_q;
    reg [15:0] psc_q;
    reg        ack_q;
    reg [31:0] rdata_d;
    reg        mapped_d;

    wire       unit_rst;
    wire       tick;
    wire       rise;
    wire       fall;
    wire       acc;
    wire       wr;
    wire       chan_start_trigger;
    wire       chan_stop_trigger;
    wire       chan_enable_status;
    wire [2:0] mode_sel;
    wire [2:0] start_trig_select;
    wire [1:0] edge_sel;
    wire [1:0] op_clock_select;
    wire       start_irq_option;
    wire       is_width;
    wire       ival_edge;
    wire       w_start;
    wire       w_capt;
    wire [3:0] psc_sel;
    wire [15:0] count_inc;

    // Mask of low prescaler bits for divide by two to the n
    function [15:0] tcpm_mask;
        input [3:0] n;
        begin
            tcpm_mask = ~(`TCPM_FULL16 << n);
        end
    endfunction

    // Edge test for interval mode by edge selection field
    function tcpm_edge_hit;
        input [1:0] sel;
        input       r;
        input       f;
        begin
            case (sel)
                `TCPM_CIS_FALL: tcpm_edge_hit = f;
                `TCPM_CIS_RISE: tcpm_edge_hit = r;
                default:        tcpm_edge_hit = r | f;
            endcase
        end
    endfunction

    assign unit_rst = srst | ~unit_power_enable_q;

    // APB: one wait state so read data comes from a flip-flop
    assign acc     = psel & penable;
    assign pready  = ack_q;
    assign pslverr = ack_q & ~mapped_d;
    assign wr      = acc & ack_q & pwrite & mapped_d;

    assign chan_start_trigger = wr & unit_power_enable_q
                              & (paddr == `TCPM_A_TRIGGER)
                              & pwdata[`TCPM_T_START];
    assign chan_stop_trigger  = wr & unit_power_enable_q
                              & (paddr == `TCPM_A_TRIGGER)
                              & pwdata[`TCPM_T_STOP];

    assign chan_enable_status = ~state_q[0];
    assign mode_sel          = chan_mode_reg_q[`TCPM_M_MD_HI:`TCPM_M_MD_LO];
    assign start_trig_select = chan_mode_reg_q[`TCPM_M_STS_HI:`TCPM_M_STS_LO];
    assign edge_sel          = chan_mode_reg_q[`TCPM_M_CIS_HI:`TCPM_M_CIS_LO];
    assign op_clock_select   = chan_mode_reg_q[`TCPM_M_CKS_HI:`TCPM_M_CKS_LO];
    assign start_irq_option  = chan_mode_reg_q[`TCPM_M_IRQOPT];
    assign is_width = (mode_sel == `TCPM_MD_ONECOUNT);
    assign count_inc = chan_count_reg_q + `TCPM_ONE16;

    // Operating clock select: one of four prescaler fields
    assign psc_sel = unit_prescaler_reg_q[op_clock_select * `TCPM_PSC_W
                                          +: `TCPM_PSC_W];
    always @(posedge clk)
    begin
        if (unit_rst)
            psc_q <= `TCPM_ZERO16;
        else
            psc_q <= psc_q + `TCPM_ONE16;
    end
    assign tick = ((psc_q & tcpm_mask(psc_sel)) == tcpm_mask(psc_sel));

    tcpm_in_filter u_filt
    (
        .clk     (clk),
        .rst     (unit_rst),
        .pin     (timer_input_pin),
        .tick    (tick),
        .filt_en (noise_filter_enable_q),
        .rise    (rise),
        .fall    (fall)
    );

    assign ival_edge = (start_trig_select == `TCPM_STS_EDGE)
                     & tcpm_edge_hit(edge_sel, rise, fall);
    assign w_start = (start_trig_select == `TCPM_STS_START)
                   & ((edge_sel == `TCPM_CIS_HIGH) ? rise :
                      (edge_sel == `TCPM_CIS_LOW)  ? fall : 1'b0);
    assign w_capt  = (edge_sel == `TCPM_CIS_HIGH) ? fall :
                     (edge_sel == `TCPM_CIS_LOW)  ? rise : 1'b0;

    // Configuration registers; unit power bit always writable
    always @(posedge clk)
    begin
        if (srst)
            unit_power_enable_q <= 1'b0;
        else if (wr && paddr == `TCPM_A_POWER)
            unit_power_enable_q <= pwdata[0];
    end

    // only edge bits change while running, trusted to software
    always @(posedge clk)
    begin
        if (unit_rst)
        begin
            unit_prescaler_reg_q  <= `TCPM_ZERO16;
            chan_mode_reg_q       <= `TCPM_ZERO16;
            out_ctl_q             <= 4'h0;
            noise_filter_enable_q <= 1'b0;
        end
        else if (wr)
        begin
            case (paddr)
                `TCPM_A_PRESCALE: unit_prescaler_reg_q <= pwdata[15:0];
                `TCPM_A_MODE:
                    chan_mode_reg_q <= pwdata[15:0] & `TCPM_M_WMASK;
                `TCPM_A_OUTCTL:   out_ctl_q <= pwdata[3:0];
                `TCPM_A_NFEN:     noise_filter_enable_q <= pwdata[0];
                default:          out_ctl_q <= out_ctl_q;
            endcase
        end
    end

    // Channel sequencer, counter, capture and interrupt
    always @(posedge clk)
    begin
        if (unit_rst)
        begin
            state_q                 <= ST_IDLE;
            chan_count_reg_q        <= `TCPM_ZERO16;
            chan_capture_data_reg_q <= `TCPM_ZERO16;
            overflow_flag_q         <= 1'b0;
            wrap_q                  <= 1'b0;
            first_q                 <= 1'b0;
            chan_interrupt          <= 1'b0;
        end
        else
        begin
            chan_interrupt <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (chan_start_trigger && !chan_stop_trigger)
                    begin
                        state_q <= is_width ? ST_WAIT : ST_RUN;
                        first_q <= ~is_width;
                    end
                end
                ST_RUN:
                begin
                    if (chan_stop_trigger)
                        state_q <= ST_IDLE;
                    else if (first_q && tick)
                    begin
                        chan_count_reg_q <= `TCPM_ZERO16;
                        wrap_q           <= 1'b0;
                        first_q          <= 1'b0;
                        chan_interrupt   <= start_irq_option;
                    end
                    else if (!first_q && (chan_start_trigger || (tick
                             && ival_edge)))
                    begin
                        chan_capture_data_reg_q <= chan_count_reg_q;
                        overflow_flag_q  <= wrap_q;
                        wrap_q           <= 1'b0;
                        chan_count_reg_q <= `TCPM_ZERO16;
                        chan_interrupt   <= 1'b1;
                    end
                    else if (!first_q && tick)
                    begin
                        chan_count_reg_q <= count_inc;
                        if (chan_count_reg_q == `TCPM_FULL16)
                            wrap_q <= 1'b1;
                    end
                end
                ST_WAIT:
                begin
                    if (chan_stop_trigger)
                        state_q <= ST_IDLE;
                    else if (tick && w_start)
                    begin
                        chan_count_reg_q <= `TCPM_ZERO16;
                        wrap_q           <= 1'b0;
                        state_q          <= ST_MEAS;
                        chan_interrupt   <= start_irq_option;
                    end
                end
                ST_MEAS:
                begin
                    if (chan_stop_trigger)
                        state_q <= ST_IDLE;
                    else if (tick && w_capt)
                    begin
                        chan_capture_data_reg_q <= chan_count_reg_q;
                        overflow_flag_q  <= wrap_q;
                        chan_count_reg_q <= count_inc;
                        chan_interrupt   <= 1'b1;
                        state_q          <= ST_WAIT;
                    end
                    else if (tick)
                    begin
                        chan_count_reg_q <= count_inc;
                        if (chan_count_reg_q == `TCPM_FULL16)
                            wrap_q <= 1'b1;
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    always @*
    begin
        rdata_d  = `TCPM_ZERO32;
        mapped_d = 1'b1;
        case (paddr)
            `TCPM_A_POWER:    rdata_d[0] = unit_power_enable_q;
            `TCPM_A_PRESCALE: rdata_d[15:0] = unit_prescaler_reg_q;
            `TCPM_A_MODE:     rdata_d[15:0] = chan_mode_reg_q;
            `TCPM_A_OUTCTL:   rdata_d[3:0] = out_ctl_q;
            `TCPM_A_TRIGGER:  rdata_d = `TCPM_ZERO32;
            `TCPM_A_ENSTAT:   rdata_d[0] = chan_enable_status;
            `TCPM_A_COUNT:    rdata_d[15:0] = chan_count_reg_q;
            `TCPM_A_CAPTURE:  rdata_d[15:0] = chan_capture_data_reg_q;
            `TCPM_A_STATUS:   rdata_d[`TCPM_OVF_BIT] = overflow_flag_q;
            `TCPM_A_NFEN:     rdata_d[0] = noise_filter_enable_q;
            default:          mapped_d = 1'b0;
        endcase
    end

    // Acknowledge after one wait cycle; read data latched then
    always @(posedge clk)
    begin
        if (srst)
        begin
            ack_q  <= 1'b0;
            prdata <= `TCPM_ZERO32;
        end
        else
        begin
            ack_q <= acc & ~ack_q;
            if (acc && !ack_q && !pwrite)
                prdata <= rdata_d;
        end
    end
endmodule

/* sim/tcpm_checker.sv */
// Port-level assertions for the measurement channel
`timescale 1ns/100ps
`include "tcpm_defines.vh"
module tcpm_checker
(
    input wire        clk,
    input wire        srst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        timer_input_pin,
    input wire        chan_interrupt
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // Bus answer after exactly one wait state
    property p_ack_wait;
        psel && penable && !pready |=> pready;
    endproperty
    property p_ack_pulse;
        pready |=> !pready;
    endproperty
    // Error only beside an answer, and only for unmapped places
    property p_err_only;
        pslverr |-> pready;
    endproperty
    property p_err_unmapped;
        pready && paddr > `TCPM_A_NFEN |-> pslverr;
    endproperty
    property p_map_ok;
        pready && paddr <= `TCPM_A_NFEN && paddr[1:0] == 2'b00
            |-> !pslverr;
    endproperty
    // Trigger bits never read back as set
    property p_trig_zero;
        pready && !pwrite && paddr == `TCPM_A_TRIGGER
            |-> prdata == `TCPM_ZERO32;
    endproperty
    property p_stat_bits;
        pready && !pwrite && paddr == `TCPM_A_STATUS
            |-> prdata[31:1] == 31'h0000_0000;
    endproperty
    // Read data moves only when a read is taken
    property p_rd_hold;
        !(psel && penable && !pready) |=> $stable(prdata);
    endproperty
    property p_irq_pulse;
        chan_interrupt |=> !chan_interrupt;
    endproperty

    a_ack_wait:      assert property (p_ack_wait)      else $error("no ack");
    a_ack_pulse:     assert property (p_ack_pulse)     else $error("ack long");
    a_err_only:      assert property (p_err_only)      else $error("stray err");
    a_err_unmapped:  assert property (p_err_unmapped)  else $error("no err");
    a_map_ok:        assert property (p_map_ok)        else $error("bad err");
    a_trig_zero:     assert property (p_trig_zero)     else $error("trig set");
    a_stat_bits:     assert property (p_stat_bits)     else $error("stat bits");
    a_rd_hold:       assert property (p_rd_hold)       else $error("rd moved");
    a_irq_pulse:     assert property (p_irq_pulse)     else $error("irq long");

    // Main scenarios reached
    c_irq: cover property (chan_interrupt);
    c_err: cover property (pslverr);
    c_cap: cover property (pready && !pwrite && paddr == `TCPM_A_CAPTURE);
endmodule

bind tcpm_channel tcpm_checker chk_u
(
    .clk             (clk),
    .srst            (srst),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .timer_input_pin (timer_input_pin),
    .chan_interrupt  (chan_interrupt)
);

/* sim/tcpm_pulse_src.sv */
// External pulse source driving the timer input pin
`timescale 1ns/100ps
module tcpm_pulse_src
(
    input  wire  clk,
    output logic pin
);
    // Pin idles low until told otherwise
    initial pin = 1'b0;

    // Hold a level for n clocks, change just after an edge
    task automatic hold(input logic v, input int n);
        pin <= v;
        repeat (n) @(posedge clk);
    endtask
endmodule

/* sim/testbench.sv */
// Self-checking bench for the measurement channel
`timescale 1ns/100ps
`include "tcpm_defines.vh"
module testbench;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin;
    logic        irq;
    logic [31:0] irq_cnt = 32'h0000_0000;
    int          error_cnt = 0;
    int          check_count = 0;

    // 50 ns period
    always #25 clk = ~clk;

    tcpm_channel dut_u
    (
        .clk             (clk),
        .srst            (srst),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .timer_input_pin (pin),
        .chan_interrupt  (irq)
    );
    tcpm_pulse_src src_u
    (
        .clk (clk),
        .pin (pin)
    );

    // Count interrupt pulses; one per event expected
    always @(posedge clk)
        if (irq === 1'b1)
            irq_cnt <= irq_cnt + 32'h0000_0001;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h", $time, what, got);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    // Idle cycle after release so the next setup never re-drives psel
    // in one step; only the watchdog ends a wait for pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input string what);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, x, what);
    endtask

    // Power off: writes dropped; unmapped place refused
    task automatic t_power;
        logic [31:0] r;
        logic        e;
        wr(`TCPM_A_MODE, 32'h0000_02CC);
        rd(`TCPM_A_MODE, 32'h0000_0000, "mode off");
        apb(1'b0, 8'h40, 32'h0000_0000, r, e);
        chk({31'h0, e}, 32'h0000_0001, "unmapped err");
        chk(r, 32'h0000_0000, "unmapped data");
        wr(`TCPM_A_POWER, 32'h0000_0001);
        rd(`TCPM_A_ENSTAT, 32'h0000_0000, "idle on");
    endtask

    // Interval: rising edges 40 clocks apart, start irq on
    task automatic t_interval;
        logic [31:0] c;
        logic        e;
        wr(`TCPM_A_MODE, 32'h0000_0145);
        wr(`TCPM_A_TRIGGER, 32'h0000_0001);
        rd(`TCPM_A_ENSTAT, 32'h0000_0001, "run");
        src_u.hold(1'b0, 5);
        chk(irq_cnt, 32'h0000_0001, "start irq");
        src_u.hold(1'b1, 20);
        src_u.hold(1'b0, 20);
        src_u.hold(1'b1, 20);
        src_u.hold(1'b0, 20);
        chk(irq_cnt, 32'h0000_0003, "edge irqs");
        rd(`TCPM_A_CAPTURE, 32'h0000_0027, "interval");
        rd(`TCPM_A_STATUS, 32'h0000_0000, "no wrap");
        wr(`TCPM_A_TRIGGER, 32'h0000_0001);
        @(posedge clk);
        chk(irq_cnt, 32'h0000_0004, "soft capture");
        wr(`TCPM_A_TRIGGER, 32'h0000_0002);
        rd(`TCPM_A_ENSTAT, 32'h0000_0000, "stopped");
        apb(1'b0, `TCPM_A_COUNT, 32'h0000_0000, c, e);
        repeat (10) @(posedge clk);
        rd(`TCPM_A_COUNT, c, "frozen");
        rd(`TCPM_A_TRIGGER, 32'h0000_0000, "self clear");
    endtask

    // Width: high 25 clocks, then low 30 clocks, no start irq
    task automatic t_width;
        wr(`TCPM_A_MODE, 32'h0000_02CC);
        wr(`TCPM_A_TRIGGER, 32'h0000_0001);
        src_u.hold(1'b0, 10);
        chk(irq_cnt, 32'h0000_0004, "no start irq");
        rd(`TCPM_A_ENSTAT, 32'h0000_0001, "wait edge");
        src_u.hold(1'b1, 25);
        src_u.hold(1'b0, 15);
        chk(irq_cnt, 32'h0000_0005, "width irq");
        rd(`TCPM_A_CAPTURE, 32'h0000_0018, "high");
        rd(`TCPM_A_COUNT, 32'h0000_0019, "plus one");
        repeat (8) @(posedge clk);
        rd(`TCPM_A_COUNT, 32'h0000_0019, "held");
        // Restart only after stop, never while enabled
        wr(`TCPM_A_TRIGGER, 32'h0000_0002);
        wr(`TCPM_A_MODE, 32'h0000_028C);
        wr(`TCPM_A_TRIGGER, 32'h0000_0001);
        src_u.hold(1'b1, 10);
        src_u.hold(1'b0, 30);
        src_u.hold(1'b1, 10);
        rd(`TCPM_A_CAPTURE, 32'h0000_001D, "low");
        wr(`TCPM_A_TRIGGER, 32'h0000_0002);
    endtask

    // Wrap during a long high level, filter on; then a short one
    task automatic t_wrap;
        wr(`TCPM_A_NFEN, 32'h0000_0001);
        wr(`TCPM_A_MODE, 32'h0000_02CC);
        wr(`TCPM_A_TRIGGER, 32'h0000_0001);
        src_u.hold(1'b0, 10);
        src_u.hold(1'b1, 65546);
        src_u.hold(1'b0, 10);
        // Width is 10000H times flag plus capture plus one
        rd(`TCPM_A_CAPTURE, 32'h0000_0009, "wrapped");
        rd(`TCPM_A_STATUS, 32'h0000_0001, "flag set");
        // Stop keeps the flag; restart waits for the next rise
        wr(`TCPM_A_TRIGGER, 32'h0000_0002);
        rd(`TCPM_A_STATUS, 32'h0000_0001, "flag kept");
        wr(`TCPM_A_TRIGGER, 32'h0000_0001);
        src_u.hold(1'b1, 12);
        src_u.hold(1'b0, 10);
        rd(`TCPM_A_CAPTURE, 32'h0000_000B, "short");
        rd(`TCPM_A_STATUS, 32'h0000_0000, "flag clr");
        // One-clock glitch must not pass the filter
        src_u.hold(1'b1, 1);
        src_u.hold(1'b0, 10);
        rd(`TCPM_A_COUNT, 32'h0000_000C, "glitch");
    endtask

    // Divided operating clock, falling edges 50 clocks apart
    task automatic t_prescale;
        logic [31:0] n0;
        n0 = irq_cnt;
        wr(`TCPM_A_PRESCALE, 32'h0000_0001);
        wr(`TCPM_A_MODE, 32'h0000_0104);
        wr(`TCPM_A_TRIGGER, 32'h0000_0001);
        src_u.hold(1'b1, 20);
        src_u.hold(1'b0, 40);
        src_u.hold(1'b1, 10);
        src_u.hold(1'b0, 20);
        rd(`TCPM_A_CAPTURE, 32'h0000_0018, "divided");
        chk(irq_cnt, n0 + 32'h0000_0002, "fall irqs");
        wr(`TCPM_A_TRIGGER, 32'h0000_0002);
    endtask

    // Power off clears the whole channel
    task automatic t_off;
        wr(`TCPM_A_POWER, 32'h0000_0000);
        rd(`TCPM_A_CAPTURE, 32'h0000_0000, "cap init");
        rd(`TCPM_A_MODE, 32'h0000_0000, "mode init");
        wr(`TCPM_A_POWER, 32'h0000_0001);
        rd(`TCPM_A_ENSTAT, 32'h0000_0000, "en init");
    endtask

    task automatic close_out;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_power;
        t_interval;
        t_width;
        t_wrap;
        t_off;
        t_prescale;
        close_out;
    end

    // Hang guard, well above the longest run
    initial
    begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        close_out;
    end
endmodule
